// file: nvac_cfg.svh
// Constants for the byte non-volatile access controller
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_DEPTH        32
`define NVAC_AW           5
`define NVAC_SEL_ADDRESS  2'h0
`define NVAC_SEL_DATA     2'h1
`define NVAC_SEL_CONTROL  2'h2
`define NVAC_CTRL_OFFSET  8'h40
`define NVAC_SECTOR_ONE   8'h01
`define NVAC_BIT_WPERMIT  3
`define NVAC_BIT_WSTART   2
`define NVAC_BIT_RPERMIT  1
`define NVAC_BIT_RSTART   0
`define NVAC_RESET_BYTE   8'h00
`define NVAC_READ_CYCLES  4'h3
`define NVAC_WRITE_TICKS  8'h40
`define NVAC_TICK_DIV     8'hC8
`endif

// file: nvac_pkg.sv
// Types for the byte non-volatile access controller
package nvac_pkg;
	typedef enum logic [1:0] {NVAC_IDLE, NVAC_READ, NVAC_WRITE} nvac_state_t;
	typedef logic [7:0] nvac_byte_t;
endpackage

// file: nvac_tick_if.sv
// Interface carrying the write timer tick between modules
`timescale 1ns/100ps
interface nvac_tick_if;
	logic tick;
	logic run;
	modport source (output tick, input run);
	modport sink   (input tick, output run);
endinterface

// file: nvac_write_timer.sv
// Divider, held at zero while not running, producing the slow write timer tick
`timescale 1ns/100ps
`include "nvac_cfg.svh"
module nvac_write_timer (
	input  wire logic   clk_in,
	input  wire logic   rst_n_in,
	nvac_tick_if.source tk
);
	logic [7:0] div;

	// Divider stands for the slow independent write oscillator
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div <= 8'h00;
		end else if (!tk.run || div == `NVAC_TICK_DIV - 8'h01) begin
			div <= 8'h00;
		end else begin
			div <= div + 8'h01;
		end
	end

	assign tk.tick = tk.run && (div == `NVAC_TICK_DIV - 8'h01);
endmodule

// file: nvac_top.sv
// Byte non-volatile store with address, data and control registers
// Summary of operation
// - Thirty-two byte store, one byte per access
// - Address keeps five bits, upper bits read zero
// - Control reached indirectly, sector one location 40H
// - Write permit zero blocks all array writes
// - Write start needs permit; cleared when done
// - Read permit zero blocks array reads
// - Read start needs permit; cleared when done
// - Read result held in data until next operation
// - Write timed by independent slow timer
// - Power-on clears all control bits
// - Write end sets done and shared flags
// - Service clears shared flag only; software clears done
`timescale 1ns/100ps
`include "nvac_cfg.svh"
module nvac_top
	import nvac_pkg::*;
(
	input  wire logic          clk_in,
	input  wire logic          rst_n_in,
	input  wire logic [1:0]    reg_sel_in,
	input  wire logic [7:0]    ptr_low_in,
	input  wire logic [7:0]    ptr_high_in,
	input  wire logic          reg_wr_in,
	input  wire nvac_pkg::nvac_byte_t reg_wdata_in,
	output nvac_pkg::nvac_byte_t      reg_rdata_out,
	input  wire logic          write_done_irq_enable_in,
	input  wire logic          multi_irq_enable_in,
	input  wire logic          global_irq_enable_in,
	input  wire logic          stack_full_in,
	input  wire logic          irq_serviced_in,
	input  wire logic          done_flag_clear_in,
	output logic               write_done_irq_flag_out,
	output logic               multi_irq_flag_out,
	output logic               irq_request_out,
	output logic               busy_out
);
	import nvac_pkg::*;

	nvac_tick_if tk ();

	nvac_byte_t  mem [0:`NVAC_DEPTH-1];
	nvac_byte_t  nv_data;
	logic [4:0]  nv_address;
	logic        write_permit;
	logic        write_start;
	logic        read_permit;
	logic        read_start;
	nvac_state_t state;
	logic [7:0]  wcount;
	logic [3:0]  rcount;
	logic [4:0]  cap_addr;
	nvac_byte_t  cap_data;
	logic        rd_go;
	logic        wr_go;
	logic        rd_end;
	logic        wr_end;

	// Control register is reached only through the sector one pointer pair
	function automatic logic ctrl_hit(input logic [1:0] sel, input logic [7:0] lo, input logic [7:0] hi);
		ctrl_hit = (sel == `NVAC_SEL_CONTROL) && (lo == `NVAC_CTRL_OFFSET) && (hi == `NVAC_SECTOR_ONE);
	endfunction

	wire ctrl_wr = reg_wr_in && ctrl_hit(reg_sel_in, ptr_low_in, ptr_high_in);
	wire addr_wr = reg_wr_in && (reg_sel_in == `NVAC_SEL_ADDRESS);
	wire data_wr = reg_wr_in && (reg_sel_in == `NVAC_SEL_DATA);

	// Start bits only take effect when the matching permit is already held
	assign wr_go  = ctrl_wr && reg_wdata_in[`NVAC_BIT_WSTART] && write_permit && state == NVAC_IDLE;
	assign rd_go  = ctrl_wr && reg_wdata_in[`NVAC_BIT_RSTART] && read_permit && state == NVAC_IDLE && !wr_go;
	assign rd_end = state == NVAC_READ && rcount == 4'h0;
	assign wr_end = state == NVAC_WRITE && tk.tick && wcount == 8'h01;
	assign tk.run = state == NVAC_WRITE;

	nvac_write_timer u_nvac_write_timer (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tk       (tk)
	);

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	// Cycle state and counters; the write length is counted in slow ticks
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state  <= NVAC_IDLE;
			rcount <= 4'h0;
			wcount <= 8'h00;
		end else begin
			case (state)
				NVAC_IDLE: begin
					if (wr_go) begin
						state  <= NVAC_WRITE;
						wcount <= `NVAC_WRITE_TICKS;
					end else if (rd_go) begin
						state  <= NVAC_READ;
						rcount <= `NVAC_READ_CYCLES;
					end
				end
				NVAC_READ: begin
					if (rd_end) state <= NVAC_IDLE;
					else rcount <= rcount - 4'h1;
				end
				NVAC_WRITE: begin
					if (wr_end) state <= NVAC_IDLE;
					else if (tk.tick) wcount <= wcount - 8'h01;
				end
				default: state <= NVAC_IDLE;
			endcase
		end
	end

	// Snapshot of target so later register writes cannot corrupt it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cap_addr <= 5'h00;
			cap_data <= `NVAC_RESET_BYTE;
		end else if (wr_go) begin
			cap_addr <= nv_address;
			cap_data <= nv_data;
		end
	end

	// Array write happens once, at the end of the timed cycle
	always_ff @(posedge clk_in) begin
		if (wr_end && write_permit) begin
			mem[cap_addr] <= cap_data;
		end
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	// Address keeps only its five location bits
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nv_address <= 5'h00;
		end else if (addr_wr) begin
			nv_address <= reg_wdata_in[`NVAC_AW-1:0];
		end
	end

	// Data register is loaded by software or by a finished read
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nv_data <= `NVAC_RESET_BYTE;
		end else if (rd_end && read_permit) begin
			nv_data <= mem[nv_address];
		end else if (data_wr) begin
			nv_data <= reg_wdata_in;
		end
	end

	// Control bits; software writes only the permits, and setting a start bit wins over its hardware clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			write_permit <= 1'b0;
			read_permit  <= 1'b0;
			write_start  <= 1'b0;
			read_start   <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				write_permit <= reg_wdata_in[`NVAC_BIT_WPERMIT];
				read_permit  <= reg_wdata_in[`NVAC_BIT_RPERMIT];
			end
			if (wr_go) write_start <= 1'b1;
			else if (wr_end) write_start <= 1'b0;
			if (rd_go) read_start <= 1'b1;
			else if (rd_end) read_start <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Interrupt flags
	// --------------------------------------------------------------
	// Write end sets both flags; setting wins over any same-cycle clear
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			write_done_irq_flag_out <= 1'b0;
			multi_irq_flag_out      <= 1'b0;
		end else begin
			if (wr_end) write_done_irq_flag_out <= 1'b1;
			else if (done_flag_clear_in) write_done_irq_flag_out <= 1'b0;
			if (wr_end) multi_irq_flag_out <= 1'b1;
			else if (irq_serviced_in) multi_irq_flag_out <= 1'b0;
		end
	end

	// Request goes out only with every enable and room on the stack
	assign irq_request_out = global_irq_enable_in && write_done_irq_enable_in && multi_irq_enable_in
		&& write_done_irq_flag_out && multi_irq_flag_out && !stack_full_in;
	assign busy_out = state != NVAC_IDLE;

	// Read-back mux; unimplemented bits and unreachable control read zero
	always_comb begin
		reg_rdata_out = 8'h00;
		case (reg_sel_in)
			`NVAC_SEL_ADDRESS: reg_rdata_out = {3'h0, nv_address};
			`NVAC_SEL_DATA:    reg_rdata_out = nv_data;
			`NVAC_SEL_CONTROL: begin
				if (ctrl_hit(reg_sel_in, ptr_low_in, ptr_high_in)) begin
					reg_rdata_out = {4'h0, write_permit, write_start, read_permit, read_start};
				end
			end
			default: reg_rdata_out = 8'h00;
		endcase
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_wstart_needs_permit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ctrl_wr && reg_wdata_in[`NVAC_BIT_WSTART] && !write_permit) |=> !write_start)
		else $error("write start accepted without permit");
	a_rstart_needs_permit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(ctrl_wr && reg_wdata_in[`NVAC_BIT_RSTART] && !read_permit && state == NVAC_IDLE) |=> !read_start)
		else $error("read start accepted without permit");
	a_read_clears_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd_go |=> read_start ##4 !read_start)
		else $error("read start not cleared after read");
	a_write_sets_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_end |=> (write_done_irq_flag_out && multi_irq_flag_out && !write_start))
		else $error("write end did not set flags");
	a_read_loads_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(rd_end && read_permit) |=> nv_data == mem[$past(nv_address)])
		else $error("read data not loaded");
	a_service_keeps_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(irq_serviced_in && !done_flag_clear_in && write_done_irq_flag_out) |=> write_done_irq_flag_out)
		else $error("service cleared done flag");
	a_addr_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		reg_sel_in == `NVAC_SEL_ADDRESS |-> reg_rdata_out[7:5] == 3'h0)
		else $error("address upper bits not zero");
	a_capture_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state == NVAC_WRITE && $past(state) == NVAC_WRITE) |-> $stable(cap_addr) && $stable(cap_data))
		else $error("captured target changed mid write");
endmodule

// file: nvac_cpu_model.sv
// Core model that drives the register port of the controller
`timescale 1ns/100ps
module nvac_cpu_model
	import nvac_pkg::*;
(
	input  wire logic        clk_in,
	output logic [1:0]       reg_sel_out,
	output logic [7:0]       ptr_low_out,
	output logic [7:0]       ptr_high_out,
	output logic             reg_wr_out,
	output nvac_pkg::nvac_byte_t reg_wdata_out,
	output logic             global_irq_enable_out
);
	import nvac_pkg::*;
	// -------------------------------------
	// Idle state of the core outputs
	// -------------------------------------
	initial begin
		reg_sel_out = 2'h0;
		ptr_low_out = 8'h00;
		ptr_high_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_wdata_out = 8'h00;
		global_irq_enable_out = 1'b1;
	end
	// Point at a register; sector one only for control, cleared otherwise
	task automatic aim(input logic [1:0] s, input bit hit);
		reg_sel_out = s;
		ptr_low_out = (s == 2'h2) ? 8'h40 : 8'h00;
		ptr_high_out = (s == 2'h2 && hit) ? 8'h01 : 8'h00;
	endtask
	// Register write; strobe stays up if the next call follows at once
	task automatic put(input logic [1:0] s, input nvac_byte_t v, input bit hit);
		@(negedge clk_in);
		aim(s, hit);
		reg_wdata_out = v;
		reg_wr_out = 1'b1;
	endtask
	// Drop the strobe; data is scrambled so stale bytes are never trusted
	task automatic idle();
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		reg_wdata_out = ~reg_wdata_out;
	endtask
	// Present a register for the combinational read
	task automatic look(input logic [1:0] s, input bit hit);
		@(negedge clk_in);
		aim(s, hit);
	endtask
	// Byte write: permit, then start in the very next cycle with interrupts off
	task automatic write_byte(input nvac_byte_t a, input nvac_byte_t d);
		put(2'h0, a, 1'b1);
		put(2'h1, d, 1'b1);
		global_irq_enable_out = 1'b0;
		put(2'h2, 8'h08, 1'b1);
		put(2'h2, 8'h0C, 1'b1);
		idle();
		global_irq_enable_out = 1'b1;
	endtask
	// Byte read: address reloaded and start set anew every time
	task automatic read_byte(input nvac_byte_t a);
		put(2'h0, a, 1'b1);
		put(2'h2, 8'h02, 1'b1);
		put(2'h2, 8'h03, 1'b1);
		idle();
	endtask
endmodule

// file: tb_nvac_top.sv
// Self-checking bench for the byte non-volatile access controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	$display("mismatch %s expected %h seen %h", nm, e, g); err_total++; end end
module tb_nvac_top;
	import nvac_pkg::*;
	typedef struct {bit kind; logic [7:0] val;} nvac_note_t;
	logic        clk_in, rst_n_in, samp, den, men, sfull, svc, dclr, gie, wr;
	logic [1:0]  sel;
	logic [7:0]  pl, ph, a, d;
	logic [31:0] rnd;
	nvac_byte_t  wdata, rdata;
	logic        dflag, mflag, irq, busy;
	logic [3:0]  stat;
	nvac_note_t  exp_q[$];
	nvac_note_t  n;
	int          err_total, compares;
	assign stat = {busy, irq, mflag, dflag};
	nvac_top u_nvac_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_sel_in(sel), .ptr_low_in(pl),
		.ptr_high_in(ph), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.write_done_irq_enable_in(den), .multi_irq_enable_in(men), .global_irq_enable_in(gie),
		.stack_full_in(sfull), .irq_serviced_in(svc), .done_flag_clear_in(dclr),
		.write_done_irq_flag_out(dflag), .multi_irq_flag_out(mflag), .irq_request_out(irq),
		.busy_out(busy));
	nvac_cpu_model u_nvac_cpu_model (.clk_in(clk_in), .reg_sel_out(sel), .ptr_low_out(pl),
		.ptr_high_out(ph), .reg_wr_out(wr), .reg_wdata_out(wdata), .global_irq_enable_out(gie));
	// ----------------------
	// Clock
	// ----------------------
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// Shift register for the random address and byte
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Note an expectation; kind 1 is {busy, irq, shared flag, done flag}
	task automatic note(input bit k, input logic [7:0] v);
		exp_q.push_back('{k, v});
		samp = 1'b1;
		@(negedge clk_in);
		samp = 1'b0;
	endtask
	task automatic see(input logic [1:0] s, input bit hit, input logic [7:0] v);
		u_nvac_cpu_model.look(s, hit);
		note(1'b0, v);
	endtask
	// Bounded poll of busy; running out is a failure
	task automatic wait_idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 20000) begin
			@(negedge clk_in);
			k++;
		end
		if (k >= 20000) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic end_of_test();
		if (err_total == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Watcher: compares the oldest note with what the outputs show
	always @(posedge clk_in) begin
		if (samp) begin
			n = exp_q.pop_front();
			if (n.kind) `CHK("status", n.val[3:0], stat)
			else `CHK("rdata", n.val, rdata)
		end
	end
	// ----------------------
	// Main sequence
	// ----------------------
	initial begin
		{rst_n_in, samp, sfull, svc, dclr, err_total, compares} = '0;
		{den, men} = 2'h3;
		rnd = 32'h7032;
		repeat (3) @(negedge clk_in);
		rst_n_in = 1'b1;
		see(2'h0, 1'b1, 8'h00);
		see(2'h1, 1'b1, 8'h00);
		see(2'h2, 1'b1, 8'h00);
		note(1'b1, 8'h00);
		u_nvac_cpu_model.put(2'h0, 8'hFF, 1'b1);
		u_nvac_cpu_model.put(2'h1, 8'hA5, 1'b1);
		u_nvac_cpu_model.put(2'h2, 8'h02, 1'b0);
		u_nvac_cpu_model.idle();
		see(2'h0, 1'b1, 8'h1F);
		see(2'h1, 1'b1, 8'hA5);
		see(2'h2, 1'b1, 8'h00);
		// Starts without permits are ignored
		u_nvac_cpu_model.put(2'h2, 8'h04, 1'b1);
		u_nvac_cpu_model.put(2'h2, 8'h01, 1'b1);
		u_nvac_cpu_model.idle();
		see(2'h2, 1'b1, 8'h00);
		note(1'b1, 8'h00);
		rnd = lfsr(rnd);
		a = {3'h0, rnd[4:0]};
		rnd = lfsr(rnd);
		d = rnd[7:0];
		// Timed write, then flags through service and clear
		u_nvac_cpu_model.write_byte(a, d);
		see(2'h2, 1'b1, 8'h0C);
		note(1'b1, 8'h08);
		wait_idle();
		see(2'h2, 1'b1, 8'h08);
		note(1'b1, 8'h07);
		sfull = 1'b1;
		note(1'b1, 8'h03);
		sfull = 1'b0;
		svc = 1'b1;
		@(negedge clk_in);
		svc = 1'b0;
		note(1'b1, 8'h01);
		dclr = 1'b1;
		@(negedge clk_in);
		dclr = 1'b0;
		note(1'b1, 8'h00);
		// Clobber the data register, then read the byte back
		u_nvac_cpu_model.put(2'h1, ~d, 1'b1);
		u_nvac_cpu_model.read_byte(a);
		note(1'b1, 8'h08);
		wait_idle();
		see(2'h2, 1'b1, 8'h02);
		see(2'h1, 1'b1, d);
		see(2'h1, 1'b1, d);
		repeat (2) @(negedge clk_in);
		end_of_test();
	end
endmodule
